// ==== core/adc_queue_scheduler.sv ====
`timescale 1ns/100ps
module adc_queue_scheduler
	import adc_queue_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [DATA_W-1:0] rdata,
	input wire logic trig1Pin,
	input wire logic trig2Pin,
	output logic convStart,
	output logic [PTR_W-1:0] convChan,
	output logic convAbort,
	input wire logic convDone,
	output logic tableNoWait
);

	typedef struct packed {
		engine_type eng;
		logic q;
		queue_status_type st1;
		queue_status_type st2;
		logic [PTR_W-1:0] ptr1;
		logic [PTR_W-1:0] ptr2;
		logic [PTR_W-1:0] sub2;
		logic [2:0] mode1;
		logic [2:0] mode2;
		logic sse1;
		logic sse2;
		logic res2;
		logic [PTR_W-1:0] bq2;
		logic cf1;
		logic pf1;
		logic ovr1;
		logic cf2;
		logic pf2;
		logic ovr2;
		table_type tbl;
		logic t1a;
		logic t1b;
		logic t1c;
		logic t2a;
		logic t2b;
		logic t2c;
		logic convStart;
		logic convAbort;
		logic [PTR_W-1:0] convChan;
		logic [DATA_W-1:0] rdata;
		logic tableNoWait;
	} state_type;

	state_type s_q;
	state_type s_d;

	function automatic logic mode_ok(input logic [2:0] m);
		return m == MODE_SW_SINGLE || m == MODE_EXT_SINGLE ||
			m == MODE_SW_CONT || m == MODE_EXT_CONT;
	endfunction

	function automatic logic is_ext(input logic [2:0] m);
		return m == MODE_EXT_SINGLE || m == MODE_EXT_CONT;
	endfunction

	function automatic logic waiting(input queue_status_type st);
		return st == Q_IDLE || st == Q_PAUSED;
	endfunction

	// Trigger source chosen by the queue mode for every subqueue
	function automatic logic trig_fn(input logic [2:0] m, input logic sse,
			input logic edgeSeen, input queue_status_type st);
		unique case (m)
			MODE_SW_SINGLE: return sse && waiting(st);
			MODE_EXT_SINGLE: return sse && edgeSeen;
			MODE_SW_CONT: return waiting(st);
			MODE_EXT_CONT: return edgeSeen;
			default: return 1'b0;
		endcase
	endfunction

	// Channel 63 or past table ends either queue; second-queue start ends the first queue only
	function automatic logic eoq_fn(input logic [PTR_W-1:0] p, input logic q,
			input logic [PTR_W-1:0] bq, input table_type t);
		if (p >= TABLE_END) begin
			return 1'b1;
		end
		return t[p[5:0]][ENTRY_CHAN_LSB +: PTR_W] == END_OF_QUEUE_CODE
			|| (!q && p == bq);
	endfunction

	function automatic logic [2:0] stat_code(input queue_status_type st);
		unique case (st)
			Q_IDLE: return STAT_CODE_IDLE;
			Q_ACTIVE: return STAT_CODE_ACTIVE;
			Q_PAUSED: return STAT_CODE_PAUSED;
			Q_SUSPENDED: return STAT_CODE_SUSPENDED;
			Q_PENDING: return STAT_CODE_PENDING;
		endcase
	endfunction

	logic edge1;
	logic edge2;
	logic tr1;
	logic tr2;
	logic preempt;
	logic [PTR_W-1:0] p;
	logic [PTR_W-1:0] np;
	logic [ENTRY_W-1:0] ent;

	always_comb begin
		s_d = s_q;
		s_d.convStart = 1'b0;
		s_d.convAbort = 1'b0;
		s_d.rdata = '0;
		ent = '0;

		s_d.t1a = trig1Pin;
		s_d.t1b = s_q.t1a;
		s_d.t1c = s_q.t1b;
		s_d.t2a = trig2Pin;
		s_d.t2b = s_q.t2a;
		s_d.t2c = s_q.t2b;
		edge1 = s_q.t1b && !s_q.t1c;
		edge2 = s_q.t2b && !s_q.t2c;

		// Register writes; hardware sets further down win over clears
		if (wrEn) begin
			if (addr <= ADDR_TABLE_LAST) begin
				s_d.tbl[addr[5:0]] = wdata[ENTRY_W-1:0];
			end
			unique case (addr)
				ADDR_FIRST_QUEUE_CONTROL: begin
					s_d.mode1 = wdata[CTRL_MODE_LSB +: 3];
					s_d.sse1 = wdata[CTRL_SSE_BIT];
				end
				ADDR_SECOND_QUEUE_CONTROL: begin
					s_d.mode2 = wdata[CTRL_MODE_LSB +: 3];
					s_d.sse2 = wdata[CTRL_SSE_BIT];
					s_d.res2 = wdata[CTRL_RESUME_BIT];
				end
				ADDR_SECOND_QUEUE_BEGIN_PTR: s_d.bq2 = wdata[PTR_W-1:0];
				ADDR_FLAGS: begin
					s_d.cf1 = s_q.cf1 && !wdata[FLAG_CF1];
					s_d.pf1 = s_q.pf1 && !wdata[FLAG_PF1];
					s_d.ovr1 = s_q.ovr1 && !wdata[FLAG_OVR1];
					s_d.cf2 = s_q.cf2 && !wdata[FLAG_CF2];
					s_d.pf2 = s_q.pf2 && !wdata[FLAG_PF2];
					s_d.ovr2 = s_q.ovr2 && !wdata[FLAG_OVR2];
				end
				default: ;
			endcase
		end

		// Read data valid only in the cycle after the strobe
		if (rdEn) begin
			if (addr <= ADDR_TABLE_LAST) begin
				s_d.rdata = {1'b0, s_q.tbl[addr[5:0]]};
			end
			unique case (addr)
				ADDR_FIRST_QUEUE_CONTROL: s_d.rdata = {5'h00, s_q.mode1};
				ADDR_SECOND_QUEUE_CONTROL: s_d.rdata = {3'h0, s_q.res2, 1'b0, s_q.mode2};
				ADDR_SECOND_QUEUE_BEGIN_PTR: s_d.rdata = {2'h0, s_q.bq2};
				ADDR_FLAGS: s_d.rdata = {2'h0, s_q.ovr2, s_q.pf2, s_q.cf2,
					s_q.ovr1, s_q.pf1, s_q.cf1};
				ADDR_STATUS: s_d.rdata = {2'h0, stat_code(s_q.st2), stat_code(s_q.st1)};
				ADDR_ACTIVE_PTR: s_d.rdata = {2'h0, s_q.q ? s_q.ptr2 : s_q.ptr1};
				default: ;
			endcase
		end

		// Trigger acceptance and overrun recording
		tr1 = trig_fn(s_q.mode1, s_q.sse1, edge1, s_q.st1);
		tr2 = trig_fn(s_q.mode2, s_q.sse2, edge2, s_q.st2);
		if (tr1) begin
			if (waiting(s_q.st1)) begin
				if (s_q.st1 == Q_IDLE) begin
					s_d.ptr1 = FIRST_QUEUE_BEGIN;
				end
				s_d.st1 = Q_PENDING;
			end else if (is_ext(s_q.mode1)) begin
				s_d.ovr1 = 1'b1;
			end
		end
		if (tr2) begin
			if (waiting(s_q.st2)) begin
				if (s_q.st2 == Q_IDLE) begin
					s_d.ptr2 = s_q.bq2;
					s_d.sub2 = s_q.bq2;
				end
				s_d.st2 = Q_PENDING;
			end else if (is_ext(s_q.mode2)) begin
				s_d.ovr2 = 1'b1;
			end
		end

		preempt = tr1 && waiting(s_q.st1) && s_q.q && s_q.eng != ENG_IDLE;
		p = s_q.q ? s_q.ptr2 : s_q.ptr1;
		np = p + PTR_STEP;
		if (p < TABLE_END) begin
			ent = s_q.tbl[p[5:0]];
		end

		if (preempt) begin
			s_d.convAbort = s_q.eng == ENG_CONV;
			s_d.st2 = Q_SUSPENDED;
			s_d.ptr2 = s_q.res2 ? s_q.ptr2 : s_q.sub2;
			s_d.eng = ENG_IDLE;
		end else begin
			unique case (s_q.eng)
				ENG_IDLE: begin
					if (s_q.st1 == Q_PENDING) begin
						s_d.q = 1'b0;
						s_d.st1 = Q_ACTIVE;
						s_d.eng = ENG_FETCH;
					end else if (s_q.st2 == Q_PENDING || s_q.st2 == Q_SUSPENDED) begin
						s_d.q = 1'b1;
						s_d.st2 = Q_ACTIVE;
						s_d.eng = ENG_FETCH;
					end
				end
				ENG_FETCH: begin
					if (eoq_fn(p, s_q.q, s_q.bq2, s_q.tbl)) begin
						s_d.eng = ENG_IDLE;
						if (s_q.q) begin
							s_d.cf2 = 1'b1;
							s_d.st2 = Q_IDLE;
							s_d.sse2 = 1'b0;
							s_d.ptr2 = s_q.bq2;
						end else begin
							s_d.cf1 = 1'b1;
							s_d.st1 = Q_IDLE;
							s_d.sse1 = 1'b0;
							s_d.ptr1 = FIRST_QUEUE_BEGIN;
						end
					end else begin
						s_d.convStart = 1'b1;
						s_d.convChan = ent[ENTRY_CHAN_LSB +: PTR_W];
						s_d.eng = ENG_CONV;
					end
				end
				ENG_CONV: begin
					if (convDone) begin
						if (s_q.q) begin
							s_d.ptr2 = np;
						end else begin
							s_d.ptr1 = np;
						end
						s_d.eng = ENG_FETCH;
						if (ent[ENTRY_PAUSE_BIT]) begin
							s_d.eng = ENG_IDLE;
							if (s_q.q) begin
								s_d.pf2 = 1'b1;
								s_d.st2 = Q_PAUSED;
								s_d.sub2 = np;
							end else begin
								s_d.pf1 = 1'b1;
								s_d.st1 = Q_PAUSED;
							end
							if (eoq_fn(np, s_q.q, s_q.bq2, s_q.tbl)) begin
								if (s_q.q) begin
									s_d.cf2 = 1'b1;
									s_d.st2 = Q_IDLE;
									s_d.sse2 = 1'b0;
									s_d.ptr2 = s_q.bq2;
								end else begin
									s_d.cf1 = 1'b1;
									s_d.st1 = Q_IDLE;
									s_d.sse1 = 1'b0;
									s_d.ptr1 = FIRST_QUEUE_BEGIN;
								end
							end
						end
					end
				end
			endcase
		end

		// Disabled or reserved queue is held idle and cut from the engine
		if (!mode_ok(s_q.mode1)) begin
			s_d.st1 = Q_IDLE;
			s_d.ptr1 = FIRST_QUEUE_BEGIN;
			if (!s_q.q && s_q.eng != ENG_IDLE) begin
				s_d.eng = ENG_IDLE;
				s_d.convStart = 1'b0;
				s_d.convAbort = s_q.eng == ENG_CONV;
			end
		end
		if (!mode_ok(s_q.mode2)) begin
			s_d.st2 = Q_IDLE;
			s_d.ptr2 = s_q.bq2;
			if (s_q.q && s_q.eng != ENG_IDLE) begin
				s_d.eng = ENG_IDLE;
				s_d.convStart = 1'b0;
				s_d.convAbort = s_q.eng == ENG_CONV;
			end
		end

		s_d.tableNoWait = s_q.mode1 == MODE_DISABLED &&
			s_q.mode2 == MODE_DISABLED;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign convStart = s_q.convStart;
	assign convChan = s_q.convChan;
	assign convAbort = s_q.convAbort;
	assign tableNoWait = s_q.tableNoWait;

endmodule

// ==== core/adc_queue_pkg.sv ====
package adc_queue_pkg;

	localparam int TABLE_DEPTH = 40;
	localparam int ENTRY_W = 7;
	localparam int PTR_W = 6;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	// Entry fields
	localparam int ENTRY_CHAN_LSB = 0;
	localparam int ENTRY_PAUSE_BIT = 6;
	localparam logic [PTR_W-1:0] END_OF_QUEUE_CODE = 6'h3f;
	localparam logic [PTR_W-1:0] TABLE_END = 6'h28;
	localparam logic [PTR_W-1:0] FIRST_QUEUE_BEGIN = 6'h00;
	localparam logic [PTR_W-1:0] PTR_STEP = 6'h01;

	// Register map
	localparam logic [ADDR_W-1:0] ADDR_TABLE_LAST = 7'h27;
	localparam logic [ADDR_W-1:0] ADDR_FIRST_QUEUE_CONTROL = 7'h40;
	localparam logic [ADDR_W-1:0] ADDR_SECOND_QUEUE_CONTROL = 7'h41;
	localparam logic [ADDR_W-1:0] ADDR_SECOND_QUEUE_BEGIN_PTR = 7'h42;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 7'h43;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h44;
	localparam logic [ADDR_W-1:0] ADDR_ACTIVE_PTR = 7'h45;

	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SSE_BIT = 3;
	localparam int CTRL_RESUME_BIT = 4;

	// Flag fields (write one to clear)
	localparam int FLAG_CF1 = 0;
	localparam int FLAG_PF1 = 1;
	localparam int FLAG_OVR1 = 2;
	localparam int FLAG_CF2 = 3;
	localparam int FLAG_PF2 = 4;
	localparam int FLAG_OVR2 = 5;

	// Status fields
	localparam int STAT1_LSB = 0;
	localparam int STAT2_LSB = 3;

	// Queue operating modes; 5..7 are reserved
	localparam logic [2:0] MODE_DISABLED = 3'h0;
	localparam logic [2:0] MODE_SW_SINGLE = 3'h1;
	localparam logic [2:0] MODE_EXT_SINGLE = 3'h2;
	localparam logic [2:0] MODE_SW_CONT = 3'h3;
	localparam logic [2:0] MODE_EXT_CONT = 3'h4;

	// Queue status codes as read by software
	localparam logic [2:0] STAT_CODE_IDLE = 3'h0;
	localparam logic [2:0] STAT_CODE_ACTIVE = 3'h1;
	localparam logic [2:0] STAT_CODE_PAUSED = 3'h2;
	localparam logic [2:0] STAT_CODE_SUSPENDED = 3'h3;
	localparam logic [2:0] STAT_CODE_PENDING = 3'h4;

	typedef enum logic [2:0] {
		Q_IDLE,
		Q_ACTIVE,
		Q_PAUSED,
		Q_SUSPENDED,
		Q_PENDING
	} queue_status_type;

	typedef enum logic [1:0] {
		ENG_IDLE,
		ENG_FETCH,
		ENG_CONV
	} engine_type;

	typedef logic [TABLE_DEPTH-1:0][ENTRY_W-1:0] table_type;

endpackage

// ==== verif/adc_queue_props.sv ====
`timescale 1ns/100ps
module adc_queue_props
	import adc_queue_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic trig1Pin,
	input wire logic trig2Pin,
	input wire logic convStart,
	input wire logic [PTR_W-1:0] convChan,
	input wire logic convAbort,
	input wire logic convDone,
	input wire logic tableNoWait
);
	logic busy_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Engine holds a started conversion
	always_ff @(posedge mclk) begin
		if (rst)
			busy_q <= 1'b0;
		else if (convStart)
			busy_q <= 1'b1;
		else if (convAbort || convDone)
			busy_q <= 1'b0;
	end
	start_pulse_a: assert property (convStart |=> !convStart)
		else $error("start pulse too long");
	done_gap_a: assert property (convDone && busy_q |=> !convStart)
		else $error("start right after done");
	no_eoq_conv_a: assert property (convStart |-> convChan != END_OF_QUEUE_CODE)
		else $error("end code converted");
	chan_hold_a: assert property ($changed(convChan) |-> convStart)
		else $error("channel moved without start");
	abort_busy_a: assert property (convAbort |-> busy_q && !convStart)
		else $error("abort while not converting");
	nowait_reset_a: assert property ($fell(rst) |-> ##[0:2] tableNoWait)
		else $error("wait states with both disabled");
	mode_nowait_a: assert property (wrEn && addr == ADDR_FIRST_QUEUE_CONTROL &&
		wdata[2:0] != 3'h0 && wdata[2:0] < 3'h5 |-> ##[1:2] !tableNoWait)
		else $error("enabled queue not seen");
	rd_quiet_a: assert property (!rdEn |=> rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule
bind adc_queue_scheduler adc_queue_props adc_queue_props_i (.mclk(mclk), .rst(rst),
	.addr(addr), .wdata(wdata), .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata),
	.trig1Pin(trig1Pin), .trig2Pin(trig2Pin), .convStart(convStart), .convChan(convChan),
	.convAbort(convAbort), .convDone(convDone), .tableNoWait(tableNoWait));

// ==== verif/conv_engine_model.sv ====
`timescale 1ns/100ps
module conv_engine_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic convStart,
	input wire logic convAbort,
	input wire logic [7:0] lat,
	output logic convDone
);
	logic [7:0] cnt_q;
	// Abort drops the conversion, no late done
	always_ff @(posedge mclk) begin
		convDone <= 1'b0;
		if (rst || convAbort)
			cnt_q <= 8'h00;
		else if (convStart)
			cnt_q <= lat;
		else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
			convDone <= (cnt_q == 8'h01);
		end
	end
endmodule

// ==== verif/adc_queue_scheduler_test.sv ====
`timescale 1ns/100ps
module adc_queue_scheduler_test
	import adc_queue_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = 7'h00;
	logic [DATA_W-1:0] wdata = 8'h00;
	logic wrEn = 1'b0;
	logic rdEn = 1'b0;
	logic trig1Pin = 1'b0;
	logic trig2Pin = 1'b0;
	logic rdLat = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic convStart, convAbort, convDone, tableNoWait;
	logic [PTR_W-1:0] convChan;
	logic [7:0] lat = 8'h04;
	logic [31:0] seed = 32'heda35070;
	logic [5:0] ch [0:10];
	logic [7:0] expRd [$];
	logic [5:0] expChan [$];
	int num_errors = 0;
	int tests_run = 0;
	always #2 mclk = ~mclk;
	adc_queue_scheduler adc_queue_scheduler_i (.mclk(mclk), .rst(rst), .addr(addr),
		.wdata(wdata), .wrEn(wrEn), .rdEn(rdEn), .rdata(rdata), .trig1Pin(trig1Pin),
		.trig2Pin(trig2Pin), .convStart(convStart), .convChan(convChan),
		.convAbort(convAbort), .convDone(convDone), .tableNoWait(tableNoWait));
	conv_engine_model conv_engine_model_i (.mclk(mclk), .rst(rst), .convStart(convStart),
		.convAbort(convAbort), .lat(lat), .convDone(convDone));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk) rdLat <= rdEn;
	always @(negedge mclk) begin
		if (rdLat)
			check(rdata, expRd.pop_front());
		if (convStart)
			check({2'h0, convChan}, expChan.size() ? {2'h0, expChan.pop_front()} : 8'hff);
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wrEn <= 1'b1;
		@(posedge mclk);
		wrEn <= 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge mclk);
		expRd.push_back(e);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge mclk);
		rdEn <= 1'b0;
	endtask
	task automatic pulse(input logic t1, input logic t2);
		@(posedge mclk);
		trig1Pin <= t1;
		trig2Pin <= t2;
		repeat (4) @(posedge mclk);
		trig1Pin <= 1'b0;
		trig2Pin <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask
	task automatic settle(input int n);
		int i;
		for (i = 0; i < 4000 && expChan.size() > 0; i++)
			@(posedge mclk);
		if (i == 4000) begin
			num_errors++;
			final_report();
		end
		repeat (n) @(posedge mclk);
	endtask
	// Random source for channels and engine latency
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic exp2(input int a, input int b);
		expChan.push_back(ch[a]);
		expChan.push_back(ch[b]);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd(ADDR_STATUS, 8'h00);
		rd(7'h50, 8'h00);
		@(negedge mclk);
		check({7'h00, tableNoWait}, 8'h01);
		for (int i = 0; i < 11; i++) begin
			seed = lfsr(seed);
			ch[i] = 6'(seed % 32'h3f);
		end
		lat <= 8'h02 + {5'h00, seed[2:0]};
		wr(7'h00, {2'h0, ch[0]});
		wr(7'h01, {2'h3, ch[1]});
		wr(7'h02, {2'h1, ch[2]});
		wr(7'h03, 8'h3f);
		wr(7'h08, {2'h0, ch[8]});
		wr(7'h09, {2'h0, ch[9]});
		wr(7'h0a, 8'h7f);
		rd(7'h01, {2'h1, ch[1]});
		wr(ADDR_FIRST_QUEUE_CONTROL, 8'h04);
		pulse(1'b1, 1'b0);
		settle(60);
		rd(ADDR_FLAGS, 8'h01);
		wr(ADDR_FLAGS, 8'h3f);
		wr(ADDR_SECOND_QUEUE_BEGIN_PTR, 8'h28);
		exp2(0, 1);
		pulse(1'b1, 1'b0);
		settle(60);
		rd(ADDR_STATUS, 8'h02);
		rd(ADDR_FLAGS, 8'h02);
		wr(ADDR_FLAGS, 8'h3f);
		expChan.push_back(ch[2]);
		pulse(1'b1, 1'b0);
		settle(60);
		rd(ADDR_FLAGS, 8'h03);
		exp2(0, 1);
		pulse(1'b1, 1'b0);
		settle(60);
		wr(ADDR_SECOND_QUEUE_CONTROL, 8'h04);
		pulse(1'b0, 1'b1);
		settle(60);
		rd(ADDR_FLAGS, 8'h0b);
		wr(ADDR_FLAGS, 8'h3f);
		wr(ADDR_SECOND_QUEUE_BEGIN_PTR, 8'h08);
		lat <= 8'h28;
		expChan.push_back(ch[8]);
		pulse(1'b0, 1'b1);
		settle(2);
		expChan.push_back(ch[2]);
		pulse(1'b1, 1'b0);
		settle(2);
		rd(ADDR_STATUS, 8'h19);
		pulse(1'b0, 1'b1);
		exp2(8, 9);
		settle(80);
		rd(ADDR_FLAGS, 8'h2b);
		wr(ADDR_FLAGS, 8'h3f);
		exp2(0, 1);
		exp2(8, 9);
		pulse(1'b1, 1'b1);
		rd(ADDR_STATUS, 8'h21);
		pulse(1'b0, 1'b1);
		settle(80);
		rd(ADDR_FLAGS, 8'h2a);
		rd(ADDR_STATUS, 8'h02);
		for (int m = 1; m < 3; m++) begin
			wr(ADDR_FLAGS, 8'h3f);
			exp2(8, 9);
			wr(ADDR_SECOND_QUEUE_CONTROL, 8'h08 | 8'(m));
			if (m == 2)
				pulse(1'b0, 1'b1);
			settle(80);
			rd(ADDR_FLAGS, 8'h08);
		end
		wr(ADDR_FIRST_QUEUE_CONTROL, 8'h00);
		wr(ADDR_SECOND_QUEUE_CONTROL, 8'h05);
		pulse(1'b1, 1'b1);
		wr(ADDR_SECOND_QUEUE_CONTROL, 8'h00);
		settle(4);
		check({7'h00, tableNoWait}, 8'h01);
		final_report();
	end
endmodule
